/* File: core/adcsq_pkg.sv */
// Package of register map, field positions, reset values and timing counts for the ADC control.
// Overview of operation
// - Scan enable set steps through selected positive inputs on mux A; clear, no scan.
// - Fill half flag, split mode only: 1 while filling 08-0F, 0 while 00-07.
// - Interrupt after every Nth sequence, N equals sequences field plus one.
// - Split select set gives two eight-word halves; clear gives one sixteen-word buffer.
// - Alternate set: first sample mux A, then B and A alternate; clear, always A.
// - Clock source bit set selects internal RC clock; clear selects system derived clock.
// - Auto sample phase lasts sample-time field conversion clock periods, 0 to 31.
// - Derived conversion clock period is divider plus one instruction cycles; max 64.
// - Unused bits of both control registers read as zero.
// - Three-bit reference field selects positive and negative references, rails or pins.
package adcsq_pkg;
  // ***************************************************************
  // Register offsets (byte addresses).
  // ***************************************************************
  localparam logic [7:0] ADCSQ_OFS_SEQ = 8'h00;
  localparam logic [7:0] ADCSQ_OFS_TIM = 8'h04;
  localparam logic [7:0] ADCSQ_OFS_STAT = 8'h08;
  localparam logic [7:0] ADCSQ_OFS_MASK = 8'h0C;
  localparam logic [7:0] ADCSQ_OFS_CTRL = 8'h10;
  localparam logic [7:0] ADCSQ_OFS_BUF = 8'h40;
  // ***************************************************************
  // Field positions and write masks.
  // ***************************************************************
  localparam int ADCSQ_B_ALT = 0;
  localparam int ADCSQ_B_SPLIT = 1;
  localparam int ADCSQ_B_SEQUENCES_PER_IRQ_LO = 2;
  localparam int ADCSQ_B_FILL = 7;
  localparam int ADCSQ_B_SCAN = 10;
  localparam int ADCSQ_B_REF_LO = 13;
  localparam int ADCSQ_B_AUTO_SAMPLE_TIME_LO = 8;
  localparam int ADCSQ_B_SRC = 15;
  localparam logic [15:0] ADCSQ_SEQ_WMASK = 16'hE43F;
  localparam logic [15:0] ADCSQ_TIM_WMASK = 16'h9FFF;
  localparam logic [15:0] ADCSQ_SEQ_RST = 16'h0000;
  localparam logic [15:0] ADCSQ_TIM_RST = 16'h0000;
  localparam logic [7:0] ADCSQ_DIV_MAX = 8'h3F;
  // Status bits: conversion interrupt, sequence done.
  localparam int ADCSQ_NEV = 2;
  // Conversion clocks taken by one conversion.
  localparam logic [4:0] ADCSQ_CONV_TADS = 5'h0C;
  // Instruction cycle is two system clocks.
  localparam int ADCSQ_CYC_NS = 50;
  localparam int ADCSQ_CLK_NS = 25;
  localparam logic [1:0] ADCSQ_CYC_CLKS = 2'(ADCSQ_CYC_NS / ADCSQ_CLK_NS);
  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_SAMPLE, ADCSQ_CONVERT} adcsq_state_type;
endpackage

/* File: core/adcsq_clkgen.sv */
// Conversion clock enable generator: RC tick or divided instruction cycle.
`timescale 1ns/1ps
module adcsq_clkgen
  import adcsq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rc_clk_tick,
  input wire logic source_rc,
  input wire logic [7:0] divider,
  output logic tad_tick
);
  logic rc_s1_q;
  logic rc_s2_q;
  logic rc_s3_q;
  logic [1:0] cyc_q;
  logic [7:0] cnt_q;
  logic [7:0] lim;
  logic cyc_tick;

  // Reserved divider codes clamp to the largest legal one.
  assign lim = (divider > ADCSQ_DIV_MAX) ? ADCSQ_DIV_MAX : divider;
  assign cyc_tick = (cyc_q == ADCSQ_CYC_CLKS - 2'h1);

  // RC tick arrives from another oscillator, so it is synchronised first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= rc_clk_tick;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  // Instruction cycle prescaler and period divider.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_q <= 2'h0;
      cnt_q <= 8'h00;
    end else begin
      cyc_q <= cyc_tick ? 2'h0 : cyc_q + 2'h1;
      if (cyc_tick) begin
        cnt_q <= (cnt_q >= lim) ? 8'h00 : cnt_q + 8'h01;
      end
    end
  end

  // Source select: rising edge of the RC clock, or the divider wrap.
  assign tad_tick = source_rc ? (rc_s2_q & ~rc_s3_q) : (cyc_tick && cnt_q >= lim);
endmodule

/* File: core/adcsq_seq.sv */
// Sample and convert sequencer producing the sample phase level, mux choice and done pulses.
`timescale 1ns/1ps
module adcsq_seq
  import adcsq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic tad_tick,
  input wire logic [4:0] sample_time,
  input wire logic alternate,
  output logic sampling,
  output logic mux_b_sel,
  output logic seq_done
);
  adcsq_state_type state_q;
  logic [4:0] cnt_q;
  logic mux_b_q;

  // Sample phase for the programmed periods, then a fixed conversion.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ADCSQ_IDLE;
      cnt_q <= 5'h00;
    end else begin
      case (state_q)
        ADCSQ_IDLE: begin
          if (enable) begin
            state_q <= ADCSQ_SAMPLE;
            cnt_q <= 5'h00;
          end
        end
        ADCSQ_SAMPLE: begin
          // A zero sample time skips straight to conversion.
          if (cnt_q >= sample_time) begin
            state_q <= ADCSQ_CONVERT;
            cnt_q <= 5'h00;
          end else if (tad_tick) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        ADCSQ_CONVERT: begin
          if (tad_tick) begin
            if (cnt_q == ADCSQ_CONV_TADS - 5'h01) begin
              state_q <= enable ? ADCSQ_SAMPLE : ADCSQ_IDLE;
              cnt_q <= 5'h00;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        default: state_q <= ADCSQ_IDLE;
      endcase
    end
  end

  assign seq_done = (state_q == ADCSQ_CONVERT) && tad_tick &&
                    (cnt_q == ADCSQ_CONV_TADS - 5'h01);
  assign sampling = (state_q == ADCSQ_SAMPLE);

  // Mux A for the first sample, then B and A alternate.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mux_b_q <= 1'b0;
    end else if (!enable || !alternate) begin
      mux_b_q <= 1'b0;
    end else if (seq_done) begin
      mux_b_q <= ~mux_b_q;
    end
  end
  assign mux_b_sel = mux_b_q;
endmodule

/* File: core/adcsq_top.sv */
// Top of the ADC sequence and timing control with its AHB-Lite register slave.
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rc_clk_tick,
  input wire logic [9:0] conv_result,
  input wire logic [3:0] scan_last,
  output logic [3:0] mux_a_channel,
  output logic mux_b_active,
  output logic sample_active,
  output logic [2:0] reference_select,
  output logic irq
);
  // ***************************************************************
  // Register state.
  // ***************************************************************
  logic [15:0] seq_q;
  logic [15:0] tim_q;
  logic [ADCSQ_NEV-1:0] stat_q;
  logic [ADCSQ_NEV-1:0] mask_q;
  logic on_q;
  logic [9:0] buf_q [0:15];
  logic [3:0] ptr_q;
  logic [3:0] seq_cnt_q;
  logic fill_q;
  logic [3:0] scan_q;
  logic [31:0] rdata_q;

  // Data phase capture.
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic take;
  logic rd_take;

  logic tad_tick;
  logic seq_done;
  logic mux_b;
  logic sampling;
  logic irq_event;
  logic [ADCSQ_NEV-1:0] ev;
  logic [3:0] n_minus1;
  logic start_req;

  // A write that turns the converter on while it is off starts a fresh fill.
  assign start_req = wr_pend_q && (addr_q == ADCSQ_OFS_CTRL) && hwdata[0] && !on_q;

  // Field views.
  logic split_mode;
  logic scan_en;
  assign split_mode = seq_q[ADCSQ_B_SPLIT];
  assign scan_en = seq_q[ADCSQ_B_SCAN];
  assign n_minus1 = seq_q[ADCSQ_B_SEQUENCES_PER_IRQ_LO +: 4];

  // ***************************************************************
  // AHB-Lite slave: zero wait state, always OKAY.
  // ***************************************************************
  assign take = hsel && hready && htrans[1];
  assign rd_take = take && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Writes land in the data phase, one cycle after the address phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        addr_q <= haddr;
      end
    end
  end

  // Control registers; unused bits are never stored so they read zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_q <= ADCSQ_SEQ_RST;
      tim_q <= ADCSQ_TIM_RST;
      mask_q <= '0;
      on_q <= 1'b0;
    end else if (wr_pend_q) begin
      case (addr_q)
        ADCSQ_OFS_SEQ: seq_q <= hwdata[15:0] & ADCSQ_SEQ_WMASK;
        ADCSQ_OFS_TIM: tim_q <= hwdata[15:0] & ADCSQ_TIM_WMASK;
        ADCSQ_OFS_MASK: mask_q <= hwdata[ADCSQ_NEV-1:0];
        ADCSQ_OFS_CTRL: on_q <= hwdata[0];
        default: ;
      endcase
    end
  end

  // Read mux, registered so hrdata comes from flip-flops in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= 32'h0000_0000;
      if (haddr >= ADCSQ_OFS_BUF && haddr < ADCSQ_OFS_BUF + 8'h40) begin
        rdata_q <= {22'h000000, buf_q[haddr[5:2]]};
      end else begin
        case (haddr)
          // The fill flag only means something in split mode.
          ADCSQ_OFS_SEQ: rdata_q <= {16'h0000, seq_q[15:8],
                                     fill_q & split_mode, seq_q[6:0]};
          ADCSQ_OFS_TIM: rdata_q <= {16'h0000, tim_q};
          ADCSQ_OFS_STAT: rdata_q <= {30'h00000000, stat_q};
          ADCSQ_OFS_MASK: rdata_q <= {30'h00000000, mask_q};
          ADCSQ_OFS_CTRL: rdata_q <= {31'h00000000, on_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign hrdata = rdata_q;

  // ***************************************************************
  // Timing and sequencing.
  // ***************************************************************
  adcsq_clkgen u_clkgen (
    .hclk(hclk),
    .hresetn(hresetn),
    .rc_clk_tick(rc_clk_tick),
    .source_rc(tim_q[ADCSQ_B_SRC]),
    .divider(tim_q[7:0]),
    .tad_tick(tad_tick)
  );

  adcsq_seq u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(on_q),
    .tad_tick(tad_tick),
    .sample_time(tim_q[ADCSQ_B_AUTO_SAMPLE_TIME_LO +: 5]),
    .alternate(seq_q[ADCSQ_B_ALT]),
    .sampling(sampling),
    .mux_b_sel(mux_b),
    .seq_done(seq_done)
  );

  assign mux_b_active = mux_b;
  assign sample_active = sampling;
  assign reference_select = seq_q[ADCSQ_B_REF_LO +: 3];
  assign mux_a_channel = scan_q;

  // ***************************************************************
  // Sequence counting, buffer pointer and scanning.
  // ***************************************************************
  assign irq_event = seq_done && (seq_cnt_q == n_minus1);

  // Count sequences; the Nth one raises the event and restarts the count.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_cnt_q <= 4'h0;
    end else if (!on_q) begin
      seq_cnt_q <= 4'h0;
    end else if (seq_done) begin
      seq_cnt_q <= irq_event ? 4'h0 : seq_cnt_q + 4'h1;
    end
  end

  // Results fill successive words; the boundary rewinds to the active area.
  // Rewinding only at start keeps a conversion that ends after stop from overwriting word 0.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_q <= 4'h0;
      fill_q <= 1'b0;
    end else if (start_req) begin
      ptr_q <= 4'h0;
      fill_q <= 1'b0;
    end else if (seq_done) begin
      if (irq_event) begin
        // Split mode swaps halves so software reads the finished one.
        fill_q <= split_mode ? ~fill_q : 1'b0;
        ptr_q <= (split_mode && !fill_q) ? 4'h8 : 4'h0;
      end else if (split_mode) begin
        ptr_q <= {fill_q, ptr_q[2:0] + 3'h1};
      end else begin
        ptr_q <= ptr_q + 4'h1;
      end
    end
  end

  // Result store written at the end of each conversion.
  always_ff @(posedge hclk) begin
    if (seq_done) begin
      buf_q[ptr_q] <= conv_result;
    end
  end

  // Scanning advances the mux A input on each mux A sample only.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_q <= 4'h0;
    end else if (!scan_en || !on_q) begin
      scan_q <= 4'h0;
    end else if (seq_done && !mux_b) begin
      scan_q <= (scan_q >= scan_last || irq_event) ? 4'h0 : scan_q + 4'h1;
    end
  end

  // ***************************************************************
  // Interrupt status: sticky, read clears, set beats clear.
  // ***************************************************************
  assign ev = {seq_done, irq_event};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= '0;
    end else begin
      if (rd_take && haddr == ADCSQ_OFS_STAT) begin
        stat_q <= ev;
      end else begin
        stat_q <= stat_q | ev;
      end
    end
  end
  assign irq = |(stat_q & mask_q);
endmodule

/* File: verif/adcsq_assertions.sv */
// Concurrent checks on the ADC control register slave and its outputs.
`timescale 1ns/1ps
module adcsq_assertions
  import adcsq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [3:0] mux_a_channel,
  input wire logic mux_b_active,
  input wire logic [2:0] reference_select,
  input wire logic irq
);
  // ********************
  // Shadow of the bus and the written registers.
  // ********************
  logic ap_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic [15:0] seq_q;
  logic [15:0] mask_q;
  logic seq_wr;
  logic rd_seq;
  assign seq_wr = ap_q && wr_q && addr_q == ADCSQ_OFS_SEQ;
  assign rd_seq = ap_q && !wr_q && addr_q == ADCSQ_OFS_SEQ;
  // Track the data phase so reads and writes are judged on the right edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      ap_q <= hsel && hready && htrans[1];
      wr_q <= hwrite;
      addr_q <= haddr;
    end
  end
  // Mirror the two written registers that the outputs depend on.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_q <= 16'h0000;
      mask_q <= 16'h0000;
    end else begin
      if (seq_wr) seq_q <= hwdata[15:0];
      if (ap_q && wr_q && addr_q == ADCSQ_OFS_MASK) mask_q <= hwdata[15:0];
    end
  end
  // ********************
  // Properties.
  // ********************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ref_follows: assert property (seq_wr |-> ##2 reference_select == seq_q[15:13])
    else $error("reference output does not follow its field");
  a_seq_zero_bits: assert property (rd_seq |-> hrdata[12:11] == 2'h0 && hrdata[9:8] == 2'h0 && !hrdata[6])
    else $error("unused sequence bits read nonzero");
  a_tim_zero_bits: assert property (ap_q && !wr_q && addr_q == ADCSQ_OFS_TIM |-> hrdata[14:13] == 2'h0)
    else $error("unused timing bits read nonzero");
  a_upper_half_zero: assert property (ap_q && !wr_q && addr_q < ADCSQ_OFS_STAT |-> hrdata[31:16] == 16'h0000)
    else $error("upper half of a control register reads nonzero");
  a_fill_needs_split: assert property (rd_seq && !hrdata[1] |-> !hrdata[7])
    else $error("fill flag set outside split mode");
  a_irq_needs_mask: assert property (irq |-> mask_q != 16'h0000 || $past(mask_q) != 16'h0000)
    else $error("interrupt high with every source masked");
  a_scan_off_zero: assert property (!seq_q[10] && !$past(seq_q[10]) |-> mux_a_channel == 4'h0)
    else $error("channel moves while scanning is off");
  a_alt_off_mux_a: assert property ($rose(mux_b_active) |-> seq_q[0] || $past(seq_q[0]))
    else $error("mux B chosen without alternate mode");
endmodule
bind adcsq_top adcsq_assertions adcsq_assertions_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .mux_a_channel(mux_a_channel), .mux_b_active(mux_b_active),
  .reference_select(reference_select), .irq(irq));

/* File: verif/tb_top.sv */
// Testbench for the ADC sequence and timing control block.
`timescale 1ns/1ps
module tb_top
  import adcsq_pkg::*;
;
  // ********************
  // Stimulus signals and design.
  // ********************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic rc_clk_tick = 1'b0;
  logic [9:0] conv_result = 10'h000;
  logic [3:0] scan_last = 4'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] mux_a_channel;
  logic mux_b_active;
  logic sample_active;
  logic [2:0] reference_select;
  logic irq;
  logic rc_run = 1'b0;
  logic [2:0] rc_cnt = 3'h0;
  logic b_s [0:17];
  logic [3:0] ch_s [0:17];
  logic ir_s [0:17];
  logic [31:0] r;
  int len0;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  adcsq_top adcsq_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rc_clk_tick(rc_clk_tick),
    .conv_result(conv_result), .scan_last(scan_last), .mux_a_channel(mux_a_channel),
    .mux_b_active(mux_b_active), .sample_active(sample_active),
    .reference_select(reference_select), .irq(irq));
  // Free running clock at 40 MHz.
  always #12.5 hclk = ~hclk;
  // Slow internal RC clock, gated so the source selection can be seen to matter.
  always @(posedge hclk) begin
    if (rc_run) begin
      rc_cnt <= rc_cnt + 3'h1;
      rc_clk_tick <= rc_cnt[2];
    end
  end
  // A hang ends the run as a failure.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("Error at %0t: timeout %h %h", $time, cyc, 0);
      close_out();
    end
  end
  // ********************
  // Tasks.
  // ********************
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; entered and left just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // Runs n sequences, records mux choice, channel and irq at each sample start.
  task automatic run(input logic [15:0] s, input logic [15:0] t, input int n, input int tp);
    int lo;
    lo = (int'(t[12:8]) - 1) * tp;
    bus(1'b1, ADCSQ_OFS_TIM, {16'h0000, t}, r);
    bus(1'b1, ADCSQ_OFS_SEQ, {16'h0000, s}, r);
    bus(1'b1, ADCSQ_OFS_CTRL, 32'h1, r);
    for (int i = 0; i < n; i++) begin
      while (sample_active !== 1'b1) @(posedge hclk);
      b_s[i] = mux_b_active;
      ch_s[i] = mux_a_channel;
      ir_s[i] = irq;
      conv_result <= 10'(i);
      len0 = 0;
      while (sample_active === 1'b1) begin
        @(posedge hclk);
        len0++;
      end
    end
    chk(32'(len0 > lo && len0 <= lo + 2 * tp), 32'h1);
    bus(1'b1, ADCSQ_OFS_CTRL, 32'h0, r);
    repeat (2000) @(posedge hclk);
    bus(1'b0, ADCSQ_OFS_STAT, 32'h0, r);
  endtask
  // ********************
  // Test sequence.
  // ********************
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ADCSQ_OFS_SEQ, 32'h0);
    chk(32'(hresp), 32'h0);
    rd(ADCSQ_OFS_TIM, 32'h0);
    bus(1'b1, ADCSQ_OFS_SEQ, 32'hFFFF_FFFF, r);
    rd(ADCSQ_OFS_SEQ, 32'h0000_E43F);
    bus(1'b1, ADCSQ_OFS_TIM, 32'hFFFF_FFFF, r);
    rd(ADCSQ_OFS_TIM, 32'h0000_9FFF);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF, r);
    rd(8'h20, 32'h0);
    // Every reference code must reach the reference output.
    for (int v = 0; v < 8; v++) begin
      bus(1'b1, ADCSQ_OFS_SEQ, 32'(v) << 13, r);
      repeat (2) @(posedge hclk);
      chk(32'(reference_select), 32'(v));
    end
    bus(1'b1, ADCSQ_OFS_MASK, 32'h1, r);
    run(16'h0005, 16'h0300, 4, 2);
    chk(32'({b_s[0], b_s[1], b_s[2], b_s[3]}), 32'h5);
    chk(32'({ir_s[1], ir_s[3]}), 32'h1);
    // Split mode, eight sequences per interrupt, scanning three inputs.
    scan_last <= 4'h2;
    run(16'h041E, 16'h0100, 10, 2);
    for (int i = 0; i < 8; i++) chk(32'({b_s[i], ch_s[i]}), 32'(i % 3));
    chk(32'({ir_s[7], ir_s[9]}), 32'h1);
    rd(ADCSQ_OFS_SEQ, 32'h0000_049E);
    rd(ADCSQ_OFS_BUF + 8'h0C, 32'h3);
    rd(ADCSQ_OFS_BUF, 32'h0);
    rd(ADCSQ_OFS_BUF + 8'h20, 32'h8);
    // The RC source must stall while its clock is still and run once it moves.
    bus(1'b1, ADCSQ_OFS_MASK, 32'h0, r);
    bus(1'b1, ADCSQ_OFS_TIM, 32'h0000_8100, r);
    bus(1'b1, ADCSQ_OFS_CTRL, 32'h1, r);
    repeat (300) @(posedge hclk);
    rd(ADCSQ_OFS_STAT, 32'h0);
    rc_run <= 1'b1;
    repeat (600) @(posedge hclk);
    chk(32'(irq), 32'h0);
    bus(1'b1, ADCSQ_OFS_CTRL, 32'h0, r);
    repeat (300) @(posedge hclk);
    bus(1'b0, ADCSQ_OFS_STAT, 32'h0, r);
    chk(32'(r[1]), 32'h1);
    rd(ADCSQ_OFS_STAT, 32'h0);
    rc_run <= 1'b0;
    run(16'h0000, 16'h02FF, 2, 128);
    close_out();
  end
endmodule
